// ===== design/ssx_pkg.sv
/*
 decode/execute constants for the subtract, swap, trap, exchange and xor slice.
 assumes a core that fetches bytes one per cycle and owns register file, ram and stack.
*/
// Overview of operation
// - subtract-with-borrow: accumulator minus operand minus carry
// - carry set on borrow from bit seven
// - half-borrow set on borrow from bit three
// - signed range flag: borrow from six xor seven
// - flag bits taken in most significant byte
// - decode subtract-with-borrow direct, indirect, bank forms
// - decode subtract byte register minus dword-indirect byte
// - nibble swap of accumulator, flags kept
// - trap: stack minus two, push pc, vector
// - trap ignores global interrupt enable
// - no interrupt right after a trap
// - byte exchange accumulator with operand, flags kept
// - digit exchange swaps low nibbles only
// - xor updates only sign and zero flags
// - xor on port uses output latch value
// - decode byte xor forms
// - decode extended xor forms
// - binary mode: extended forms and trap need prefix
// - source mode: legacy indirect/bank forms need prefix
// - mode comes from configuration bit only
package ssx_pkg;
    localparam logic [7:0] ESCAPE_PREFIX = 8'ha5;
    localparam logic [7:0] OP_SBB_IMM = 8'h94;
    localparam logic [7:0] OP_SBB_DIR = 8'h95;
    localparam logic [6:0] OP_SBB_IND = 7'h4b;
    localparam logic [4:0] OP_SBB_REG = 5'h13;
    localparam logic [7:0] OP_SUB_EXT = 8'h9e;
    localparam logic [3:0] SUB_DWORD_IND = 4'hb;
    localparam logic [3:0] SUB_SECOND_LOW = 4'h0;
    localparam logic [7:0] OP_SWAP = 8'hc4;
    localparam logic [7:0] OP_TRAP = 8'hb9;
    localparam logic [7:0] OP_EXCH_DIR = 8'hc5;
    localparam logic [6:0] OP_EXCH_IND = 7'h63;
    localparam logic [4:0] OP_EXCH_REG = 5'h19;
    localparam logic [6:0] OP_DEXCH_IND = 7'h6b;
    localparam logic [7:0] OP_XOR_DIR_A = 8'h62;
    localparam logic [7:0] OP_XOR_DIR_IMM = 8'h63;
    localparam logic [7:0] OP_XOR_A_IMM = 8'h64;
    localparam logic [7:0] OP_XOR_A_DIR = 8'h65;
    localparam logic [6:0] OP_XOR_A_IND = 7'h33;
    localparam logic [4:0] OP_XOR_A_REG = 5'h0d;
    localparam logic [7:0] OP_XOR_BYTE_PAIR = 8'h6c;
    localparam logic [7:0] OP_XOR_WORD_PAIR = 8'h6d;
    localparam logic [7:0] OP_XOR_EXT = 8'h6e;
    localparam logic [3:0] XOR_EXT_IMM_B = 4'h0;
    localparam logic [3:0] XOR_EXT_IMM_W = 4'h4;
    localparam logic [3:0] XOR_EXT_DIR_B = 4'h1;
    localparam logic [3:0] XOR_EXT_DIR_W = 4'h5;
    localparam logic [23:0] TRAP_VECTOR = 24'hff007b;
    localparam logic [15:0] STACK_STEP = 16'h0002;
    localparam logic [7:0] ACC_RESET = 8'h00;

    typedef enum logic [3:0] {
        SSX_K_NONE, SSX_K_SBB, SSX_K_SUB, SSX_K_SWAP, SSX_K_TRAP, SSX_K_EXCH,
        SSX_K_DEXCH, SSX_K_XOR_A, SSX_K_XOR_DIR, SSX_K_XOR_B, SSX_K_XOR_W
    } ssx_kind_type;

    // operand source the core must supply on operand_b; xor-to-direct forms name the other operand and take the direct byte there
    typedef enum logic [2:0] {
        SSX_S_IMM, SSX_S_DIR, SSX_S_IND, SSX_S_BANK, SSX_S_ACC, SSX_S_REG, SSX_S_DRAM
    } ssx_src_type;
endpackage

// ===== design/ssx_exec.sv
/*
 single-cycle decode and execute of the slice.
 assumes fetch presents a whole instruction (prefix flag, opcode, two following bytes)
 and the core supplies operand values; results are registered and handed back.
*/
`timescale 1ns/1ps
module ssx_exec (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic source_mode,
    input wire logic insn_valid,
    input wire logic insn_prefixed,
    input wire logic [7:0] insn_opcode,
    input wire logic [7:0] insn_byte1,
    input wire logic [7:0] insn_byte2,
    input wire logic [15:0] operand_a,
    input wire logic [15:0] operand_b,
    input wire logic operand_b_is_port,
    input wire logic [7:0] port_latch,
    input wire logic [7:0] acc_in,
    input wire logic [15:0] stack_top_pointer,
    input wire logic [23:0] pc_next,
    input wire logic irq_request,
    output ssx_pkg::ssx_kind_type decoded_kind,
    output ssx_pkg::ssx_src_type decoded_src,
    output logic decode_hit,
    output logic result_valid,
    output logic [15:0] result_q,
    output logic [7:0] acc_q,
    output logic [7:0] mem_write_q,
    output logic mem_write_en_q,
    output logic carry_flag,
    output logic half_borrow_flag,
    output logic signed_range_flag,
    output logic sign_flag,
    output logic zero_flag,
    output logic trap_taken_q,
    output logic [15:0] stack_top_pointer_q,
    output logic [23:0] stack_push_q,
    output logic [23:0] pc_load_q,
    output logic irq_take
);
    import ssx_pkg::*;

    ssx_kind_type kind;
    ssx_src_type src;
    logic hit, legacy_ok, ext_ok, port_sel;
    logic [7:0] a8, b8, res8, orig8;
    logic [8:0] diff;
    logic [4:0] low_diff;
    logic [7:0] low7_diff;
    logic borrow7, borrow6;
    logic [15:0] xw;
    logic [15:0] result_d, stp_d;
    logic [7:0] acc_d, mem_d;
    logic mem_en_d, carry_d, half_d, range_d, n_d, z_d, trap_d, valid_d;
    logic carry_q, half_q, range_q, n_q, z_q, trap_q, valid_q;
    logic [15:0] res_q, stp_q;
    logic [7:0] accr_q, mem_q;
    logic memen_q;
    logic [23:0] push_q, pcl_q, push_d, pcl_d;

    // legacy indirect/bank forms need the prefix only in source mode
    assign legacy_ok = (insn_prefixed == source_mode);
    // extended forms and trap need the prefix only in binary mode
    assign ext_ok = (insn_prefixed != source_mode);

    always_comb begin
        kind = SSX_K_NONE;
        src = SSX_S_IMM;
        if (insn_valid) begin
            if (insn_opcode == OP_SBB_IMM && !insn_prefixed) begin
                kind = SSX_K_SBB;
            end else if (insn_opcode == OP_SBB_DIR && !insn_prefixed) begin
                kind = SSX_K_SBB;
                src = SSX_S_DIR;
            end else if (insn_opcode[7:1] == OP_SBB_IND && legacy_ok) begin
                kind = SSX_K_SBB;
                src = SSX_S_IND;
            end else if (insn_opcode[7:3] == OP_SBB_REG && legacy_ok) begin
                kind = SSX_K_SBB;
                src = SSX_S_BANK;
            end else if (insn_opcode == OP_SUB_EXT && ext_ok
                    && insn_byte1[3:0] == SUB_DWORD_IND
                    && insn_byte2[3:0] == SUB_SECOND_LOW) begin
                kind = SSX_K_SUB;
                src = SSX_S_DRAM;
            end else if (insn_opcode == OP_SWAP && !insn_prefixed) begin
                kind = SSX_K_SWAP;
            end else if (insn_opcode == OP_TRAP && ext_ok) begin
                kind = SSX_K_TRAP;
            end else if (insn_opcode == OP_EXCH_DIR && !insn_prefixed) begin
                kind = SSX_K_EXCH;
                src = SSX_S_DIR;
            end else if (insn_opcode[7:1] == OP_EXCH_IND && legacy_ok) begin
                kind = SSX_K_EXCH;
                src = SSX_S_IND;
            end else if (insn_opcode[7:3] == OP_EXCH_REG && legacy_ok) begin
                kind = SSX_K_EXCH;
                src = SSX_S_BANK;
            end else if (insn_opcode[7:1] == OP_DEXCH_IND && legacy_ok) begin
                kind = SSX_K_DEXCH;
                src = SSX_S_IND;
            end else if (insn_opcode == OP_XOR_DIR_A && !insn_prefixed) begin
                kind = SSX_K_XOR_DIR;
                src = SSX_S_ACC;
            end else if (insn_opcode == OP_XOR_DIR_IMM && !insn_prefixed) begin
                kind = SSX_K_XOR_DIR;
            end else if (insn_opcode == OP_XOR_A_IMM && !insn_prefixed) begin
                kind = SSX_K_XOR_A;
            end else if (insn_opcode == OP_XOR_A_DIR && !insn_prefixed) begin
                kind = SSX_K_XOR_A;
                src = SSX_S_DIR;
            end else if (insn_opcode[7:1] == OP_XOR_A_IND && legacy_ok) begin
                kind = SSX_K_XOR_A;
                src = SSX_S_IND;
            end else if (insn_opcode == OP_XOR_BYTE_PAIR && ext_ok) begin
                kind = SSX_K_XOR_B;
                src = SSX_S_REG;
            end else if (insn_opcode == OP_XOR_WORD_PAIR && ext_ok) begin
                kind = SSX_K_XOR_W;
                src = SSX_S_REG;
            end else if (insn_opcode == OP_XOR_EXT && ext_ok) begin
                unique case (insn_byte1[3:0])
                    XOR_EXT_IMM_B: kind = SSX_K_XOR_B;
                    XOR_EXT_IMM_W: kind = SSX_K_XOR_W;
                    XOR_EXT_DIR_B: begin
                        kind = SSX_K_XOR_B;
                        src = SSX_S_DIR;
                    end
                    XOR_EXT_DIR_W: begin
                        kind = SSX_K_XOR_W;
                        src = SSX_S_DIR;
                    end
                    default: kind = SSX_K_NONE;
                endcase
            end else if (insn_opcode[7:3] == OP_XOR_A_REG && legacy_ok) begin
                // 6c..6e match here too; legacy_ok and ext_ok never both hold,
                // so the prefix alone keeps all eight bank registers reachable
                kind = SSX_K_XOR_A;
                src = SSX_S_BANK;
            end
        end
    end
    assign hit = (kind != SSX_K_NONE);

    // subtract datapath; sub uses the byte register and ignores carry
    assign port_sel = operand_b_is_port && kind == SSX_K_XOR_DIR;
    assign orig8 = port_sel ? port_latch : operand_b[7:0];
    assign a8 = (kind == SSX_K_SUB) ? operand_a[7:0] : acc_in;
    assign b8 = operand_b[7:0];
    assign diff = {1'b0, a8} - {1'b0, b8} - {8'h00, (kind == SSX_K_SBB) & carry_q};
    assign low_diff = {1'b0, a8[3:0]} - {1'b0, b8[3:0]} - {4'h0, (kind == SSX_K_SBB) & carry_q};
    assign low7_diff = {1'b0, a8[6:0]} - {1'b0, b8[6:0]} - {7'h00, (kind == SSX_K_SBB) & carry_q};
    assign borrow7 = diff[8];
    assign borrow6 = low7_diff[7];
    assign xw = operand_a ^ operand_b;

    always_comb begin
        acc_d = accr_q;
        result_d = res_q;
        mem_d = 8'h00;
        mem_en_d = 1'b0;
        carry_d = carry_q;
        half_d = half_q;
        range_d = range_q;
        n_d = n_q;
        z_d = z_q;
        trap_d = 1'b0;
        stp_d = stp_q;
        push_d = push_q;
        pcl_d = pcl_q;
        res8 = 8'h00;
        unique case (kind)
            SSX_K_SBB, SSX_K_SUB: begin
                res8 = diff[7:0];
                if (kind == SSX_K_SBB) begin
                    acc_d = res8;
                end
                result_d = {8'h00, res8};
                carry_d = borrow7;
                half_d = low_diff[4];
                range_d = borrow6 ^ borrow7;
                n_d = res8[7];
                z_d = (res8 == 8'h00);
            end
            SSX_K_SWAP: acc_d = {acc_in[3:0], acc_in[7:4]};
            SSX_K_TRAP: begin
                // taken unconditionally, interrupt enable is not consulted
                trap_d = 1'b1;
                stp_d = stack_top_pointer - STACK_STEP;
                push_d = pc_next;
                pcl_d = TRAP_VECTOR;
            end
            SSX_K_EXCH: begin
                acc_d = b8;
                mem_d = acc_in;
                mem_en_d = 1'b1;
            end
            SSX_K_DEXCH: begin
                acc_d = {acc_in[7:4], b8[3:0]};
                mem_d = {b8[7:4], acc_in[3:0]};
                mem_en_d = 1'b1;
            end
            SSX_K_XOR_A, SSX_K_XOR_DIR, SSX_K_XOR_B: begin
                res8 = (kind == SSX_K_XOR_A) ? (acc_in ^ b8)
                     : (kind == SSX_K_XOR_DIR) ? (orig8 ^ (src == SSX_S_ACC ? acc_in
                                                 : insn_byte2))
                     : xw[7:0];
                if (kind == SSX_K_XOR_A) begin
                    acc_d = res8;
                end
                mem_d = res8;
                mem_en_d = (kind == SSX_K_XOR_DIR);
                result_d = {8'h00, res8};
                n_d = res8[7];
                z_d = (res8 == 8'h00);
            end
            SSX_K_XOR_W: begin
                result_d = xw;
                n_d = xw[15];
                z_d = (xw == 16'h0000);
            end
            SSX_K_NONE: begin
            end
        endcase
    end
    assign valid_d = hit;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            accr_q <= ACC_RESET;
            res_q <= 16'h0000;
            mem_q <= 8'h00;
            memen_q <= 1'b0;
            carry_q <= 1'b0;
            half_q <= 1'b0;
            range_q <= 1'b0;
            n_q <= 1'b0;
            z_q <= 1'b0;
            trap_q <= 1'b0;
            valid_q <= 1'b0;
            stp_q <= 16'h0000;
            push_q <= 24'h000000;
            pcl_q <= 24'h000000;
        end else begin
            accr_q <= acc_d;
            res_q <= result_d;
            mem_q <= mem_d;
            memen_q <= mem_en_d;
            carry_q <= carry_d;
            half_q <= half_d;
            range_q <= range_d;
            n_q <= n_d;
            z_q <= z_d;
            trap_q <= trap_d;
            valid_q <= valid_d;
            stp_q <= stp_d;
            push_q <= push_d;
            pcl_q <= pcl_d;
        end
    end

    assign decoded_kind = kind;
    assign decoded_src = src;
    assign decode_hit = hit;
    assign result_valid = valid_q;
    assign result_q = res_q;
    assign acc_q = accr_q;
    assign mem_write_q = mem_q;
    assign mem_write_en_q = memen_q;
    assign carry_flag = carry_q;
    assign half_borrow_flag = half_q;
    assign signed_range_flag = range_q;
    assign sign_flag = n_q;
    assign zero_flag = z_q;
    assign trap_taken_q = trap_q;
    assign stack_top_pointer_q = stp_q;
    assign stack_push_q = push_q;
    assign pc_load_q = pcl_q;
    // the boundary right after a trap is closed to interrupts
    assign irq_take = irq_request && !trap_q;

    a_trap_vector: assert property (@(posedge sys_clk) disable iff (rst)
        kind == SSX_K_TRAP |=> trap_q && pcl_q == TRAP_VECTOR
            && stp_q == $past(stack_top_pointer) - STACK_STEP)
        else $error("trap vector or stack wrong");
    a_trap_irq_block: assert property (@(posedge sys_clk) disable iff (rst)
        kind == SSX_K_TRAP |=> !irq_take)
        else $error("interrupt taken after trap");
    a_sbb_borrow: assert property (@(posedge sys_clk) disable iff (rst)
        kind == SSX_K_SBB && acc_in < b8 |=> carry_q)
        else $error("borrow not flagged");
    a_sbb_result: assert property (@(posedge sys_clk) disable iff (rst)
        kind == SSX_K_SBB |=> accr_q == $past(acc_in) - $past(b8) - {7'h00, $past(carry_q)})
        else $error("subtract with borrow result wrong");
    a_swap_flags: assert property (@(posedge sys_clk) disable iff (rst)
        kind == SSX_K_SWAP |=> $stable(carry_q) && $stable(z_q)
            && accr_q == {$past(acc_in[3:0]), $past(acc_in[7:4])})
        else $error("nibble swap wrong");
    a_xor_keeps_carry: assert property (@(posedge sys_clk) disable iff (rst)
        kind inside {SSX_K_XOR_A, SSX_K_XOR_DIR, SSX_K_XOR_B, SSX_K_XOR_W}
            |=> $stable(carry_q) && $stable(half_q) && $stable(range_q))
        else $error("xor touched arithmetic flags");
    a_dexch_upper: assert property (@(posedge sys_clk) disable iff (rst)
        kind == SSX_K_DEXCH |=> accr_q[7:4] == $past(acc_in[7:4])
            && mem_q[7:4] == $past(b8[7:4]))
        else $error("digit exchange changed upper nibble");
    a_legacy_prefix: assert property (@(posedge sys_clk) disable iff (rst)
        insn_valid && source_mode && !insn_prefixed && insn_opcode[7:1] == OP_DEXCH_IND
            |-> kind != SSX_K_DEXCH)
        else $error("unprefixed legacy form decoded in source mode");
endmodule // ssx_exec

// ===== tb/ssx_exec_tb.sv
/*
 self-checking bench for ssx_exec: subtract with borrow, swap, trap, exchange and xor.
 assumes ssx_pkg is compiled first; the bench stands in for fetch and the core.
*/
`timescale 1ns/1ps
module ssx_exec_tb;
    import ssx_pkg::*;
    logic sys_clk, rst, source_mode, insn_valid, insn_prefixed, operand_b_is_port, irq_request;
    logic [7:0] insn_opcode, insn_byte1, insn_byte2, port_latch, acc_in, acc_q, mem_write_q;
    logic [15:0] operand_a, operand_b, stack_top_pointer, result_q, stack_top_pointer_q;
    logic [23:0] pc_next, stack_push_q, pc_load_q;
    ssx_kind_type decoded_kind;
    ssx_src_type decoded_src;
    ssx_kind_type kd;
    ssx_src_type sd;
    logic decode_hit, result_valid, mem_write_en_q, carry_flag, half_borrow_flag;
    logic signed_range_flag, sign_flag, zero_flag, trap_taken_q, irq_take, hit;
    int n_errors = 0;
    int n_checks = 0;

    ssx_exec u_ssx_exec (
        .sys_clk, .rst, .source_mode, .insn_valid, .insn_prefixed, .insn_opcode,
        .insn_byte1, .insn_byte2, .operand_a, .operand_b, .operand_b_is_port,
        .port_latch, .acc_in, .stack_top_pointer, .pc_next, .irq_request,
        .decoded_kind, .decoded_src, .decode_hit, .result_valid, .result_q, .acc_q,
        .mem_write_q, .mem_write_en_q, .carry_flag, .half_borrow_flag,
        .signed_range_flag, .sign_flag, .zero_flag, .trap_taken_q,
        .stack_top_pointer_q, .stack_push_q, .pc_load_q, .irq_take
    );

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    task automatic chk(input logic ok, input string msg);
        n_checks++;
        if (ok !== 1'b1) begin
            n_errors++;
            $display("mismatch at %0t: %s", $time, msg);
        end
    endtask

    task automatic wrap_up();
        if (n_errors == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // inputs change at the falling edge so the taking edge never races them
    task automatic issue(input logic p, input logic [7:0] op, b1, b2, acc,
                         input logic [15:0] a, b);
        insn_valid = 1'b1;
        insn_prefixed = p;
        insn_opcode = op;
        insn_byte1 = b1;
        insn_byte2 = b2;
        acc_in = acc;
        operand_a = a;
        operand_b = b;
        #1;
        hit = decode_hit;
        kd = decoded_kind;
        sd = decoded_src;
        @(posedge sys_clk);
        @(negedge sys_clk);
    endtask

    task automatic do_reset(input logic mode);
        rst = 1'b1;
        insn_valid = 1'b0;
        source_mode = mode;
        repeat (5) @(posedge sys_clk);
        @(negedge sys_clk);
        rst = 1'b0;
        chk(acc_q === 8'h00 && carry_flag === 1'b0 && trap_taken_q === 1'b0, "reset state");
    endtask

    // refused encodings must leave accumulator and write strobes alone
    task automatic refused(input logic p, input logic [7:0] op);
        logic [7:0] acc_old;
        acc_old = acc_q;
        issue(p, op, 8'h1b, 8'h00, 8'h5a, 16'h00a5, 16'h00a5);
        chk(hit === 1'b0 && result_valid === 1'b0 && trap_taken_q === 1'b0, "refused decode");
        chk(acc_q === acc_old && mem_write_en_q === 1'b0, "refused hold");
    endtask

    function automatic logic [10:0] sbb_ref(input logic [7:0] a, b, input logic c);
        logic [8:0] d;
        logic [4:0] h;
        logic [7:0] s;
        d = {1'b0, a} - {1'b0, b} - {8'h00, c};
        h = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, c};
        s = {1'b0, a[6:0]} - {1'b0, b[6:0]} - {7'h00, c};
        return {d[8], h[4], d[8] ^ s[7], d[7:0]};
    endfunction

    // the table chains the borrow and ends with it set, for the flag-keeping tests
    task automatic t_sbb();
        logic [7:0] ops [5] = '{8'h97, 8'h95, 8'h94, 8'h98, 8'h9f};
        logic [7:0] av [5] = '{8'h05, 8'h80, 8'h00, 8'hc9, 8'h10};
        logic [7:0] bv [5] = '{8'h05, 8'h01, 8'h01, 8'h54, 8'h20};
        logic brw;
        logic [10:0] e;
        brw = 1'b0;
        for (int i = 0; i < 5; i++) begin
            e = sbb_ref(av[i], bv[i], brw);
            issue(1'b0, ops[i], bv[i], 8'h00, av[i], 16'h0000, {8'h00, bv[i]});
            chk(hit === 1'b1 && result_valid === 1'b1, "sbb decode");
            chk(acc_q === e[7:0], "sbb acc");
            chk(carry_flag === e[10], "sbb borrow");
            chk(half_borrow_flag === e[9], "sbb half");
            chk(signed_range_flag === e[8], "sbb range");
            chk(sign_flag === e[7] && zero_flag === (e[7:0] == 8'h00), "sbb sz");
            brw = e[10];
        end
    endtask

    task automatic t_trap(input logic p);
        logic c;
        c = carry_flag;
        stack_top_pointer = 16'h0100;
        pc_next = 24'h123456;
        irq_request = 1'b1;
        issue(p, 8'hb9, 8'h00, 8'h00, 8'h77, 16'h0000, 16'h0000);
        chk(hit === 1'b1 && trap_taken_q === 1'b1, "trap taken");
        chk(stack_top_pointer_q === 16'h00fe && stack_push_q === 24'h123456, "push");
        chk(pc_load_q === 24'hff007b && carry_flag === c, "trap vector");
        chk(irq_take === 1'b0, "irq after trap");
        insn_valid = 1'b0;
        @(posedge sys_clk);
        @(negedge sys_clk);
        chk(irq_take === 1'b1 && trap_taken_q === 1'b0, "irq later");
    endtask

    task automatic t_exch(input logic p);
        logic [7:0] ops [3] = '{8'hc5, 8'hc7, 8'hcc};
        logic [1:0] f;
        f = {carry_flag, sign_flag};
        for (int i = 0; i < 3; i++) begin
            issue(p && (i > 0), ops[i], 8'h20, 8'h00, 8'h3f, 16'h0000, 16'h0075);
            chk(hit === 1'b1 && acc_q === 8'h75, "exchange acc");
            chk(mem_write_en_q === 1'b1 && mem_write_q === 8'h3f, "exchange mem");
        end
        issue(p, 8'hd6, 8'h00, 8'h00, 8'h36, 16'h0000, 16'h0075);
        chk(hit === 1'b1 && acc_q === 8'h35 && mem_write_q === 8'h76, "digit");
        chk(kd === SSX_K_DEXCH && sd === SSX_S_IND, "digit decode");
        chk(f === {carry_flag, sign_flag}, "exchange flags");
    endtask

    task automatic xor_b(input logic p, input logic [7:0] op, b1, b2, acc,
                         input logic [15:0] b, input logic mem, input logic [7:0] r);
        logic [2:0] f;
        f = {carry_flag, half_borrow_flag, signed_range_flag};
        issue(p, op, b1, b2, acc, 16'h0000, b);
        chk(hit === 1'b1 && (mem ? (mem_write_q === r && mem_write_en_q === 1'b1)
            : acc_q === r), "xor result");
        chk(f === {carry_flag, half_borrow_flag, signed_range_flag}, "xor flags");
        chk(sign_flag === r[7] && zero_flag === (r == 8'h00), "xor sz");
    endtask

    task automatic xor_w(input logic p, input logic [7:0] op, b1,
                         input logic [15:0] a, b, r, input logic w);
        issue(p, op, b1, 8'h00, 8'h00, a, b);
        chk(hit === 1'b1 && result_q === r && result_valid === 1'b1, "xor ext");
        chk(sign_flag === (w ? r[15] : r[7]) && zero_flag === (r == 16'h0000), "xor ext sz");
    endtask

    task automatic t_swap();
        issue(1'b0, 8'hc4, 8'h00, 8'h00, 8'hc5, 16'h0000, 16'h0000);
        chk(hit === 1'b1 && acc_q === 8'h5c, "swap acc");
        chk(carry_flag === 1'b1 && sign_flag === 1'b1, "swap flags");
    endtask

    // binary mode: the unprefixed extended opcodes are the bank register forms
    task automatic t_bank_alias();
        logic c;
        logic [7:0] r;
        c = carry_flag;
        r = 8'h0d - {7'h00, c};
        xor_b(1'b0, 8'h6d, 8'h00, 8'h00, 8'hc3, 16'h00aa, 1'b0, 8'h69);
        chk(kd === SSX_K_XOR_A && sd === SSX_S_BANK, "bank xor decode");
        issue(1'b0, 8'h9e, 8'h1b, 8'h20, 8'h10, 16'h0010, 16'h0003);
        chk(kd === SSX_K_SBB && acc_q === r && carry_flag === 1'b0, "bank sbb");
        chk(result_valid === 1'b1 && result_q === {8'h00, r}, "bank sbb result");
    endtask

    // extended subtract hands back result_q and the flags, never the accumulator
    task automatic t_sub_ext();
        logic [7:0] acc_old;
        acc_old = acc_q;
        issue(1'b1, 8'h9e, 8'h1b, 8'h20, 8'h00, 16'h0010, 16'h0003);
        chk(hit === 1'b1 && result_q[7:0] === 8'h0d, "dword indirect sub");
        chk(kd === SSX_K_SUB && acc_q === acc_old, "dword indirect sub acc");
        issue(1'b1, 8'h9e, 8'h1b, 8'h21, 8'h00, 16'h0010, 16'h0003);
        chk(hit === 1'b0, "sub second byte");
    endtask

    initial begin
        rst = 1'b1;
        source_mode = 1'b0;
        insn_valid = 1'b0;
        insn_prefixed = 1'b0;
        insn_opcode = 8'h00;
        insn_byte1 = 8'h00;
        insn_byte2 = 8'h00;
        operand_a = 16'h0000;
        operand_b = 16'h0000;
        operand_b_is_port = 1'b0;
        port_latch = 8'h00;
        acc_in = 8'h00;
        stack_top_pointer = 16'h0000;
        pc_next = 24'h000000;
        irq_request = 1'b0;
        @(negedge sys_clk);
        do_reset(1'b0);
        t_sbb();
        refused(1'b1, 8'h98);
        t_swap();
        t_trap(1'b1);
        refused(1'b0, 8'hb9);
        t_exch(1'b0);
        port_latch = 8'haa;
        operand_b_is_port = 1'b1;
        xor_b(1'b0, 8'h62, 8'h90, 8'h00, 8'hc3, 16'h0055, 1'b1, 8'h69);
        operand_b_is_port = 1'b0;
        xor_b(1'b0, 8'h63, 8'h30, 8'h0f, 8'h00, 16'h003c, 1'b1, 8'h33);
        xor_b(1'b0, 8'h64, 8'haa, 8'h00, 8'hc3, 16'h00aa, 1'b0, 8'h69);
        xor_b(1'b0, 8'h65, 8'h30, 8'h00, 8'hc3, 16'h00aa, 1'b0, 8'h69);
        xor_b(1'b0, 8'h67, 8'h00, 8'h00, 8'hc3, 16'h00c3, 1'b0, 8'h00);
        xor_b(1'b0, 8'h6b, 8'h00, 8'h00, 8'hc3, 16'h0043, 1'b0, 8'h80);
        xor_w(1'b1, 8'h6c, 8'h12, 16'h00f0, 16'h000f, 16'h00ff, 1'b0);
        xor_w(1'b1, 8'h6d, 8'h24, 16'h8000, 16'h0001, 16'h8001, 1'b1);
        xor_w(1'b1, 8'h6e, 8'h30, 16'h0055, 16'h00aa, 16'h00ff, 1'b0);
        xor_w(1'b1, 8'h6e, 8'h34, 16'h1234, 16'h0204, 16'h1030, 1'b1);
        xor_w(1'b1, 8'h6e, 8'h31, 16'h0055, 16'h0055, 16'h0000, 1'b0);
        xor_w(1'b1, 8'h6e, 8'h35, 16'h0055, 16'h0055, 16'h0000, 1'b1);
        t_bank_alias();
        t_sub_ext();
        do_reset(1'b1);
        refused(1'b0, 8'h98);
        refused(1'b0, 8'h68);
        issue(1'b1, 8'h9a, 8'h00, 8'h00, 8'h10, 16'h0000, 16'h0001);
        chk(hit === 1'b1 && acc_q === 8'h0f && half_borrow_flag === 1'b1, "src sbb");
        t_trap(1'b0);
        t_exch(1'b1);
        xor_b(1'b1, 8'h68, 8'h00, 8'h00, 8'hc3, 16'h00aa, 1'b0, 8'h69);
        xor_w(1'b0, 8'h6c, 8'h12, 16'h00f0, 16'h000f, 16'h00ff, 1'b0);
        wrap_up();
    end

    // the whole sequence needs well under 200 cycles
    initial begin
        #(2000 * 10);
        n_errors++;
        wrap_up();
    end
endmodule // ssx_exec_tb
